// ---- logic/ee_cfg.svh ----
`ifndef EE_CFG_SVH
`define EE_CFG_SVH

// core clock rate
`define EE_CLK_MHZ        250
// spike width that sets the pin filter length, rounded down to whole cycles
`define EE_T_SPIKE_NS     10
`define EE_SPIKE_CYC      ((`EE_T_SPIKE_NS * `EE_CLK_MHZ) / 1000)
// self-timed programming time
`define EE_T_WR_US        5000
`define EE_WR_CYC         (`EE_T_WR_US * `EE_CLK_MHZ)
// control byte layout
`define EE_DEV_CODE       4'hA
`define EE_CODE_HI        7
`define EE_CODE_LO        4
`define EE_BLK_HI         3
`define EE_BLK_LO         1
`define EE_RW_BIT         0
// bits per byte on the wire, counted from zero
`define EE_BYTE_BITS      4'h8
// write page is 16 bytes
`define EE_PAGE_BITS      4
// idle level of the filtered pins
`define EE_PIN_IDLE       1'b1

`endif

// ---- logic/ee_pkg.sv ----
`default_nettype none

package ee_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CTRL  = 3'b001,
        ST_WADDR = 3'b010,
        ST_WDATA = 3'b011,
        ST_SACK  = 3'b100,
        ST_RDATA = 3'b101,
        ST_MACK  = 3'b110
    } ee_state_e;

    typedef logic [10:0] ee_addr_t;
endpackage

`default_nettype wire

// ---- logic/ee_pin_filter.sv ----
`default_nettype none

module ee_pin_filter #(
    parameter int   STABLE  = 2,
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic pin_i,
    output logic      filt_o
);
    if (STABLE < 1 || STABLE > 255) begin : g_bad_stable
        $error("ee_pin_filter: STABLE out of range");
    end

    logic       sync1;
    logic       sync2;
    logic [7:0] cnt;

    wire differs = sync2 != filt_o;
    wire settled = cnt == 8'(STABLE - 1);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1 <= RST_VAL;
            sync2 <= RST_VAL;
        end else begin
            sync1 <= pin_i;
            sync2 <= sync1;
        end
    end

    // a level must hold STABLE cycles before it is believed
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt    <= 8'h00;
            filt_o <= RST_VAL;
        end else if (!differs) begin
            cnt    <= 8'h00;
        end else if (settled) begin
            cnt    <= 8'h00;
            filt_o <= sync2;
        end else begin
            cnt    <= cnt + 8'h01;
        end
    end
endmodule // ee_pin_filter

`default_nettype wire

// ---- logic/ee_slave.sv ----
`include "ee_cfg.svh"
`default_nettype none

module ee_slave #(
    parameter int WR_CYCLES = `EE_WR_CYC,
    parameter int SPIKE_CYC = `EE_SPIKE_CYC
) (
    input  wire logic CORE_CLK_I,
    input  wire logic RSTN_I,
    input  wire logic SCL_I,
    input  wire logic SDA_I,
    input  wire logic WP_I,
    output logic      SDA_O,
    output logic      SDA_OE_N_O,
    output logic      WRITE_BUSY_O
);
    import ee_pkg::*;

    // the busy counter counts in 24 bits and the pin filters in eight, so longer windows cannot be served
    if (WR_CYCLES < 1 || WR_CYCLES > 16777215) begin : g_bad_wr_cycles
        $error("ee_slave: WR_CYCLES out of range");
    end
    if (SPIKE_CYC < 1 || SPIKE_CYC > 255) begin : g_bad_spike_cyc
        $error("ee_slave: SPIKE_CYC out of range");
    end

    logic       scl_f;
    logic       sda_f;
    logic       lock;
    logic       scl_q;
    logic       sda_q;
    ee_state_e  state;
    ee_state_e  next_state;
    ee_state_e  ret_state;
    ee_state_e  next_ret_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic       sda_oe_n;
    logic       next_sda_oe_n;
    logic       mack;
    logic       next_mack;
    ee_addr_t   ptr;
    logic [2:0] blk;
    logic       wr_pend;
    logic [23:0] busy_cnt;
    logic [7:0] mem [0:2047];

    ee_pin_filter #(.STABLE(SPIKE_CYC), .RST_VAL(`EE_PIN_IDLE)) u_scl_filt (
        .clk_i  (CORE_CLK_I),
        .rstn_i (RSTN_I),
        .pin_i  (SCL_I),
        .filt_o (scl_f)
    );
    ee_pin_filter #(.STABLE(SPIKE_CYC), .RST_VAL(`EE_PIN_IDLE)) u_sda_filt (
        .clk_i  (CORE_CLK_I),
        .rstn_i (RSTN_I),
        .pin_i  (SDA_I),
        .filt_o (sda_f)
    );
    // lock comes up set so nothing programs before the pin is seen
    ee_pin_filter #(.STABLE(SPIKE_CYC), .RST_VAL(1'b1)) u_wp_filt (
        .clk_i  (CORE_CLK_I),
        .rstn_i (RSTN_I),
        .pin_i  (WP_I),
        .filt_o (lock)
    );

    wire scl_rise  = scl_f & ~scl_q;
    wire scl_fall  = ~scl_f & scl_q;
    wire start_det = scl_f & scl_q & sda_q & ~sda_f;
    wire stop_det  = scl_f & scl_q & ~sda_q & sda_f;
    wire busy      = busy_cnt != 24'h000000;
    wire byte_done = scl_fall && bit_cnt == `EE_BYTE_BITS;
    wire rx_bit    = scl_rise && bit_cnt != `EE_BYTE_BITS;
    wire code_ok   = shreg[`EE_CODE_HI:`EE_CODE_LO] == `EE_DEV_CODE;
    wire ctrl_ack  = state == ST_CTRL && byte_done && code_ok && !busy;
    wire ctrl_rd   = shreg[`EE_RW_BIT];
    wire waddr_ack = state == ST_WADDR && byte_done;
    wire wdata_end = state == ST_WDATA && byte_done;
    wire mem_we    = wdata_end && !lock;
    // no lock term here: the lock never blocks reads
    wire rd_load   = scl_fall && ((state == ST_SACK && ret_state == ST_RDATA)
                                  || (state == ST_MACK && mack));
    wire [7:0] rd_byte = mem[ptr];
    wire [10:0] ptr_inc = ptr + 11'h001;
    wire [10:0] ptr_wr_inc = {ptr[10:`EE_PAGE_BITS], ptr[3:0] + 4'h1};
    wire start_wr  = stop_det && wr_pend && !busy;

    always_comb begin
        next_state     = state;
        next_ret_state = ret_state;
        next_bit_cnt   = bit_cnt;
        next_shreg     = shreg;
        next_sda_oe_n  = sda_oe_n;
        next_mack      = mack;
        if (start_det) begin
            next_state    = ST_CTRL;
            next_bit_cnt  = 4'h0;
            next_sda_oe_n = 1'b1;
        end else if (stop_det) begin
            next_state    = ST_IDLE;
            next_sda_oe_n = 1'b1;
        end else if (rd_load) begin
            next_shreg    = rd_byte;
            next_sda_oe_n = rd_byte[7];
            next_bit_cnt  = 4'h1;
            next_state    = ST_RDATA;
        end else begin
            unique case (state)
                ST_IDLE: begin
                end
                ST_CTRL, ST_WADDR, ST_WDATA: begin
                    if (rx_bit) begin
                        next_shreg   = {shreg[6:0], sda_f};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        next_bit_cnt = 4'h0;
                        next_state   = ST_SACK;
                        next_sda_oe_n = 1'b0;
                        if (state == ST_CTRL) begin
                            next_ret_state = ctrl_rd ? ST_RDATA : ST_WADDR;
                            if (!ctrl_ack) begin
                                next_state    = ST_IDLE;
                                next_sda_oe_n = 1'b1;
                            end
                        end else if (state == ST_WADDR) begin
                            next_ret_state = ST_WDATA;
                        end else begin
                            next_ret_state = ST_WDATA;
                            if (lock) begin
                                next_state    = ST_IDLE;
                                next_sda_oe_n = 1'b1;
                            end
                        end
                    end
                end
                ST_SACK: begin
                    if (scl_fall) begin
                        next_sda_oe_n = 1'b1;
                        next_state    = ret_state;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == `EE_BYTE_BITS) begin
                            next_sda_oe_n = 1'b1;
                            next_state    = ST_MACK;
                        end else begin
                            next_shreg    = {shreg[6:0], 1'b0};
                            next_sda_oe_n = shreg[6];
                            next_bit_cnt  = bit_cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        next_mack = ~sda_f;
                    end else if (scl_fall) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state    = ST_IDLE;
                    next_sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            scl_q     <= `EE_PIN_IDLE;
            sda_q     <= `EE_PIN_IDLE;
            state     <= ST_IDLE;
            ret_state <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            sda_oe_n  <= 1'b1;
            mack      <= 1'b0;
        end else begin
            scl_q     <= scl_f;
            sda_q     <= sda_f;
            state     <= next_state;
            ret_state <= next_ret_state;
            bit_cnt   <= next_bit_cnt;
            shreg     <= next_shreg;
            sda_oe_n  <= next_sda_oe_n;
            mack      <= next_mack;
        end
    end

    // pointer survives start and stop so a later read continues from it
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ptr <= 11'h000;
            blk <= 3'h0;
        end else if (ctrl_ack) begin
            blk <= shreg[`EE_BLK_HI:`EE_BLK_LO];
        end else if (waddr_ack) begin
            ptr <= {blk, shreg};
        end else if (mem_we) begin
            ptr <= ptr_wr_inc;
        end else if (rd_load) begin
            ptr <= ptr_inc;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (mem_we) begin
            mem[ptr] <= shreg;
        end
    end

    // a start clears wr_pend, not the bytes already in mem, so a repeated start never starts a programming cycle
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_pend <= 1'b0;
        end else if (mem_we) begin
            wr_pend <= 1'b1;
        end else if (start_det || stop_det) begin
            wr_pend <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            busy_cnt     <= 24'h000000;
            WRITE_BUSY_O <= 1'b0;
            SDA_O        <= 1'b0;
        end else begin
            if (start_wr) begin
                busy_cnt <= 24'(WR_CYCLES);
            end else if (busy) begin
                busy_cnt <= busy_cnt - 24'h000001;
            end
            WRITE_BUSY_O <= start_wr || busy_cnt > 24'h000001;
            SDA_O        <= 1'b0;
        end
    end

    assign SDA_OE_N_O = sda_oe_n;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    sequence s_rd_load;
        rd_load;
    endsequence
    sequence s_refused_byte;
        wdata_end && lock;
    endsequence

    a_lock_no_pend: assert property (lock && !wr_pend |=> !wr_pend)
        else $error("write pending while locked");
    a_lock_nack: assert property (s_refused_byte |=> sda_oe_n && state == ST_IDLE)
        else $error("locked data byte acknowledged");
    a_stop_no_prog: assert property (stop_det && !wr_pend && !busy |=> !busy)
        else $error("programming started without data");
    a_ctrl_ack: assert property (ctrl_ack |=> !sda_oe_n && state == ST_SACK)
        else $error("control byte not acknowledged");
    a_busy_nack: assert property (state == ST_CTRL && byte_done && busy |=> sda_oe_n)
        else $error("control byte acknowledged while busy");
    a_waddr_load: assert property (waddr_ack |=> ptr == {blk, $past(shreg)})
        else $error("word address not loaded");
    a_read_msb: assert property (s_rd_load |=>
        sda_oe_n == shreg[7] && ptr == $past(ptr) + 11'h001)
        else $error("read byte msb or pointer wrong");
    a_bus_release: assert property (start_det || stop_det |=> sda_oe_n)
        else $error("data line held across start or stop");
    a_nack_idle: assert property (state == ST_MACK && scl_fall && !mack |=>
        state == ST_IDLE)
        else $error("read did not end on master nack");
    a_busy_runs: assert property ($rose(busy) |-> $past(wr_pend) ##1 busy)
        else $error("programming cycle without written data");
    a_ptr_wrap: assert property (s_rd_load && ptr == 11'h7FF |=> ptr == 11'h000)
        else $error("read pointer did not wrap");
    a_page_step: assert property (mem_we |=>
        ptr[10:`EE_PAGE_BITS] == $past(ptr[10:`EE_PAGE_BITS])
        && ptr[3:0] == $past(ptr[3:0]) + 4'h1)
        else $error("write pointer left its page");
endmodule // ee_slave

`default_nettype wire

// ---- test/ee_host_model.sv ----
`default_nettype none

module ee_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus: clock stands high, data released to the pull-up
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // releases data first so the same task also serves as a repeated start
    task automatic start();
        tick(5);
        sda_low_o = 1'b0;
        tick(5);
        scl_o = 1'b1;
        tick(5);
        sda_low_o = 1'b1;
        tick(5);
        scl_o = 1'b0;
    endtask

    // one core clock wide pulse on the low clock line, shorter than the filter window
    task automatic clk_spike();
        tick(5);
        scl_o = 1'b1;
        tick(1);
        scl_o = 1'b0;
    endtask

    task automatic stop();
        tick(5);
        sda_low_o = 1'b1;
        tick(5);
        scl_o = 1'b1;
        tick(10);
        sda_low_o = 1'b0;
        tick(10);
    endtask

    // nine bits, 80 ns each; data moves mid low phase, sampled mid high phase
    task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            tick(5);
            sda_low_o = ~tx[i];
            tick(5);
            scl_o = 1'b1;
            tick(5);
            rx[i] = sda_i;
            tick(5);
            scl_o = 1'b0;
        end
    endtask
endmodule // ee_host_model

`default_nettype wire

// ---- test/serial_eeprom_read_and_protect_bench.sv ----
`default_nettype none

module serial_eeprom_read_and_protect_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // long enough for a polling frame to land inside the busy window
    localparam int WR_CYC = 2000;

    logic core_clk;
    logic rstn;
    logic wp;
    logic scl;
    logic host_low;
    logic sda_out;
    logic sda_oe_n;
    logic busy;
    wire  sda;
    int   n_errors = 0;
    int   n_checks = 0;

    // open-drain line with pull-up
    assign sda = ~(host_low | (~sda_oe_n & ~sda_out));

    ee_slave #(.WR_CYCLES(WR_CYC), .SPIKE_CYC(2)) i_dut (
        .CORE_CLK_I(core_clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda), .WP_I(wp),
        .SDA_O(sda_out), .SDA_OE_N_O(sda_oe_n), .WRITE_BUSY_O(busy));

    ee_host_model i_host (.clk_i(core_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic put(input logic [7:0] d, output logic ack);
        logic [8:0] rx;
        i_host.xbyte({d, 1'b1}, rx);
        ack = ~rx[0];
    endtask

    task automatic get(input logic mack, output logic [7:0] d);
        logic [8:0] rx;
        i_host.xbyte({8'hFF, ~mack}, rx);
        d = rx[8:1];
    endtask

    task automatic seek(input logic [10:0] a);
        logic ack;
        i_host.start();
        put({4'hA, a[10:8], 1'b0}, ack);
        chk("seek ctrl ack", 8'(ack), 8'h01);
        put(a[7:0], ack);
        chk("seek addr ack", 8'(ack), 8'h01);
        i_host.start();
        put({4'hA, a[10:8], 1'b1}, ack);
        chk("read ctrl ack", 8'(ack), 8'h01);
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d0, input logic [7:0] d1);
        logic ack;
        int   n;
        i_host.start();
        put({4'hA, a[10:8], 1'b0}, ack);
        chk("wr ctrl ack", 8'(ack), 8'h01);
        put(a[7:0], ack);
        chk("wr addr ack", 8'(ack), 8'h01);
        put(d0, ack);
        chk("wr data0 ack", 8'(ack), 8'h01);
        put(d1, ack);
        chk("wr data1 ack", 8'(ack), 8'h01);
        i_host.stop();
        chk("busy after stop", 8'(busy), 8'h01);
        i_host.start();
        put(8'hA0, ack);
        chk("poll while busy", 8'(ack), 8'h00);
        i_host.stop();
        n = 0;
        while (busy !== 1'b0 && n < 2 * WR_CYC) begin
            @(negedge core_clk);
            n++;
        end
        chk("busy ends", 8'(busy), 8'h00);
        i_host.start();
        put(8'hA0, ack);
        chk("poll when done", 8'(ack), 8'h01);
        i_host.stop();
    endtask

    task automatic t_write();
        wr(11'h712, 8'h5A, 8'hA5);
        // second byte wraps within the page, landing at 0x7F0
        wr(11'h7FF, 8'h3C, 8'h99);
        wr(11'h000, 8'hC3, 8'h11);
        $display("write test done");
    endtask

    task automatic t_read();
        logic [7:0] d;
        logic       ack;
        seek(11'h712);
        get(1'b0, d);
        chk("random read", d, 8'h5A);
        i_host.stop();
        chk("released", 8'(sda_oe_n), 8'h01);
        i_host.start();
        put(8'hA1, ack);
        chk("current ctrl ack", 8'(ack), 8'h01);
        get(1'b0, d);
        chk("current read", d, 8'hA5);
        i_host.stop();
        seek(11'h7FF);
        get(1'b1, d);
        chk("seq first", d, 8'h3C);
        get(1'b0, d);
        chk("seq wrap", d, 8'hC3);
        i_host.stop();
        $display("read test done");
    endtask

    task automatic t_lock();
        logic [7:0] d;
        logic       ack;
        wp = 1'b1;
        repeat (20) @(negedge core_clk);
        i_host.start();
        put(8'hAE, ack);
        chk("locked ctrl ack", 8'(ack), 8'h01);
        put(8'h12, ack);
        chk("locked addr ack", 8'(ack), 8'h01);
        put(8'h00, ack);
        chk("locked data nack", 8'(ack), 8'h00);
        i_host.stop();
        chk("no busy when locked", 8'(busy), 8'h00);
        seek(11'h712);
        get(1'b0, d);
        chk("locked content", d, 8'h5A);
        i_host.stop();
        wp = 1'b0;
        repeat (20) @(negedge core_clk);
        $display("lock test done");
    endtask

    task automatic t_code();
        logic ack;
        i_host.start();
        put(8'h5E, ack);
        chk("foreign code nack", 8'(ack), 8'h00);
        i_host.stop();
        chk("idle after foreign", 8'(sda_oe_n), 8'h01);
        $display("code test done");
    endtask

    // an unfiltered spike would shift an extra bit and spoil the control byte
    task automatic t_spike();
        logic [7:0] d;
        logic       ack;
        i_host.start();
        i_host.clk_spike();
        put(8'hA1, ack);
        chk("spike ctrl ack", 8'(ack), 8'h01);
        get(1'b0, d);
        chk("spike current read", d, 8'hA5);
        i_host.stop();
        $display("spike test done");
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // a full run needs about 13000 cycles
    initial begin
        repeat (80000) @(posedge core_clk);
        n_errors++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        rstn = 1'b0;
        wp   = 1'b0;
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        repeat (12) @(negedge core_clk);
        t_write();
        t_read();
        t_lock();
        t_code();
        t_spike();
        summarize();
    end
endmodule // serial_eeprom_read_and_protect_bench

`default_nettype wire
